// >>> watchdog_hibernate_pkg.sv
package watchdog_hibernate_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_SYSTEM_CONTROL_TWO = 8'h04;
   localparam logic [7:0] IDX_HIBERNATE_CONTROL = 8'h05;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h08;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h09;
   localparam logic [7:0] IDX_SECURITY_KEY = 8'h0A;
   localparam int ADDR_SCALE = 4;

   // Field positions in system_control_two
   localparam int ACTION_LSB = 4;
   localparam int PERIOD_LSB = 0;
   // Field positions in hibernate_control
   localparam int HIB_STATE_BIT = 15;
   localparam int HIB_WDOG_BIT = 7;
   localparam int HIB_STARTUP_BIT = 6;
   localparam int HIB_REGCLR_BIT = 5;
   localparam int HIB_RSTPIN_BIT = 4;
   localparam int HIB_IRQMASK_BIT = 3;
   localparam int HIB_MEMORY_RESET_OUT_N_BIT = 2;
   localparam int HIB_COMP_BIT = 1;
   localparam int HIB_THERM_BIT = 0;
   localparam logic [15:0] HIB_WRITE_MASK = 16'h80FF;

   // Interrupt status bit positions
   localparam int IRQ_TIMEOUT_BIT = 0;
   localparam int IRQ_RESET_WAKE_BIT = 1;

   // Values after reset
   localparam logic [1:0] ACTION_RESET = 2'h0;
   localparam logic [2:0] PERIOD_RESET = 3'h4;
   localparam logic [15:0] HIB_RESET = 16'h0000;
   localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

   // Security key value that unlocks protected fields
   localparam logic [15:0] KEY_UNLOCK = 16'h00C3;

   // Timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int TICK_TIME_NS = 125000000;
   localparam int TICK_CYCLES = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [5:0] STARTUP_CYCLES = 6'h10;
   localparam logic [5:0] SYS_RESET_CYCLES = 6'h10;

   typedef enum logic [1:0] {
      ACTION_OFF,
      ACTION_IRQ,
      ACTION_RESET_ONLY,
      ACTION_TWO_STAGE
   } action_t;

   typedef enum {
      ST_ACTIVE,
      ST_HIBERNATE,
      ST_STARTUP,
      ST_SYSRESET
   } power_state_t;
endpackage

// >>> watchdog_hibernate_control.sv
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
module watchdog_hibernate_control
   import watchdog_hibernate_pkg::*;
#(
   parameter int TICK_PERIOD = TICK_CYCLES
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [15:0] regRdData,
   input wire logic host_alive_pulse,
   output logic sysResetOutN,
   output logic memory_reset_out_n,
   output logic irqOut,
   output logic comparatorEnable,
   output logic thermalEnable,
   output logic startupActive,
   output logic hibernateActive
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [1:0] watchdog_action_select;
   logic [2:0] watchdog_period_select;
   logic [15:0] hibCtrl;
   logic [1:0] irqStatus;
   logic [1:0] irqMask;
   logic keyUnlocked;
   power_state_t powerState;
   logic [5:0] stateCount;
   logic [31:0] tickCount;
   logic tick;
   logic [5:0] wdCount;
   logic firstExpired;
   logic [2:0] beatSync;
   logic beatEdge;
   logic wdRunning;
   logic expiry;
   logic watchdog_timeout_irq;
   logic watchdog_reset_wake_irq;
   logic wdResetReq;
   logic hibExit;
   logic regClear;
   logic inHib;
   logic wrCtrl2;
   logic wrHib;
   logic wrMask;
   logic wrKey;
   logic rdStatus;
   logic [7:0] wordIdx;
   logic addrAligned;
   logic [5:0] reloadValue;
   logic [2:0] nextPeriod;

   ////////////////////////////////////////////////////////////////////////
   // Address decode
   assign wordIdx = regAddr / 8'(ADDR_SCALE);
   assign addrAligned = (regAddr % 8'(ADDR_SCALE)) == 8'h00;
   assign wrCtrl2 = regWr && addrAligned && wordIdx == IDX_SYSTEM_CONTROL_TWO;
   assign wrHib = regWr && addrAligned && wordIdx == IDX_HIBERNATE_CONTROL;
   assign wrMask = regWr && addrAligned && wordIdx == IDX_IRQ_MASK;
   assign wrKey = regWr && addrAligned && wordIdx == IDX_SECURITY_KEY;
   assign rdStatus = regRd && addrAligned && wordIdx == IDX_IRQ_STATUS;

   ////////////////////////////////////////////////////////////////////////
   // Host_alive_pulse synchroniser and edge detect
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         beatSync <= 3'h0;
      end else begin
         beatSync <= {beatSync[1:0], host_alive_pulse};
      end
   end

   assign beatEdge = beatSync[2] != beatSync[1];

   ////////////////////////////////////////////////////////////////////////
   // Slow timebase, one tick per eighth of a second
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tickCount <= 32'h0;
      end else if (tickCount >= 32'(TICK_PERIOD - 1)) begin
         tickCount <= 32'h0;
      end else begin
         tickCount <= tickCount + 32'h1;
      end
   end

   assign tick = tickCount >= 32'(TICK_PERIOD - 1);

   ////////////////////////////////////////////////////////////////////////
   // Security key
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         keyUnlocked <= 1'b0;
      end else if (wrKey) begin
         keyUnlocked <= regWrData == KEY_UNLOCK;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Watchdog configuration
   assign regClear = wdResetReq || (hibExit && hibCtrl[HIB_REGCLR_BIT]);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         watchdog_action_select <= ACTION_RESET;
         watchdog_period_select <= PERIOD_RESET;
      end else if (regClear) begin
         watchdog_action_select <= ACTION_RESET;
         watchdog_period_select <= PERIOD_RESET;
      end else if (wrCtrl2 && keyUnlocked) begin
         watchdog_action_select <= regWrData[ACTION_LSB +: 2];
         if (regWrData[PERIOD_LSB + 2 -: 2] != 2'h3) begin
            watchdog_period_select <= regWrData[PERIOD_LSB +: 3];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Watchdog timer
   assign inHib = powerState == ST_HIBERNATE;
   assign wdRunning = watchdog_action_select != ACTION_OFF
      && (powerState == ST_ACTIVE || (inHib && hibCtrl[HIB_WDOG_BIT]));
   // Reload with the period being written, so a new timeout applies at once
   assign nextPeriod = regClear ? PERIOD_RESET
      : (wrCtrl2 && keyUnlocked && regWrData[PERIOD_LSB + 2 -: 2] != 2'h3) ? regWrData[PERIOD_LSB +: 3]
      : watchdog_period_select;
   assign reloadValue = 6'h1 << nextPeriod;
   assign expiry = wdRunning && tick && wdCount == 6'h1;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wdCount <= 6'h10;
         firstExpired <= 1'b0;
      end else if (beatEdge || wrCtrl2 || !wdRunning) begin
         wdCount <= reloadValue;
         firstExpired <= 1'b0;
      end else if (expiry) begin
         wdCount <= reloadValue;
         firstExpired <= watchdog_action_select == ACTION_TWO_STAGE;
      end else if (tick) begin
         wdCount <= wdCount - 6'h1;
      end
   end

   assign watchdog_timeout_irq = expiry && (watchdog_action_select == ACTION_IRQ
      || (watchdog_action_select == ACTION_TWO_STAGE && !firstExpired));
   assign wdResetReq = expiry && (watchdog_action_select == ACTION_RESET_ONLY
      || (watchdog_action_select == ACTION_TWO_STAGE && firstExpired));
   assign watchdog_reset_wake_irq = wdResetReq;

   ////////////////////////////////////////////////////////////////////////
   // Hibernate control register
   assign hibExit = inHib && !hibCtrl[HIB_STATE_BIT];

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         hibCtrl <= HIB_RESET;
      end else if (regClear) begin
         hibCtrl <= HIB_RESET;
      end else if (wrHib) begin
         hibCtrl <= regWrData & HIB_WRITE_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Power state machine
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         powerState <= ST_ACTIVE;
         stateCount <= 6'h0;
      end else if (wdResetReq) begin
         powerState <= ST_SYSRESET;
         stateCount <= SYS_RESET_CYCLES;
      end else begin
         case (powerState)
            ST_ACTIVE: begin
               if (hibCtrl[HIB_STATE_BIT]) begin
                  powerState <= ST_HIBERNATE;
               end
            end
            ST_HIBERNATE: begin
               if (hibExit && hibCtrl[HIB_STARTUP_BIT]) begin
                  powerState <= ST_STARTUP;
                  stateCount <= STARTUP_CYCLES;
               end else if (hibExit) begin
                  powerState <= ST_ACTIVE;
               end
            end
            ST_STARTUP, ST_SYSRESET: begin
               if (stateCount <= 6'h1) begin
                  powerState <= ST_ACTIVE;
                  stateCount <= 6'h0;
               end else begin
                  stateCount <= stateCount - 6'h1;
               end
            end
            default: begin
               powerState <= ST_ACTIVE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status and mask
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irqStatus <= 2'h0;
      end else begin
         irqStatus[IRQ_TIMEOUT_BIT] <= watchdog_timeout_irq
            || (irqStatus[IRQ_TIMEOUT_BIT] && !rdStatus);
         irqStatus[IRQ_RESET_WAKE_BIT] <= watchdog_reset_wake_irq
            || (irqStatus[IRQ_RESET_WAKE_BIT] && !rdStatus);
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irqMask <= IRQ_MASK_RESET;
      end else if (wrMask) begin
         irqMask <= regWrData[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data, one cycle after the strobe
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         regRdData <= 16'h0000;
      end else if (regRd && addrAligned) begin
         case (wordIdx)
            IDX_SYSTEM_CONTROL_TWO: begin
               regRdData <= {10'h000, watchdog_action_select, 1'b0, watchdog_period_select};
            end
            IDX_HIBERNATE_CONTROL: begin
               regRdData <= hibCtrl;
            end
            IDX_IRQ_STATUS: begin
               regRdData <= {14'h0000, irqStatus};
            end
            IDX_IRQ_MASK: begin
               regRdData <= {14'h0000, irqMask};
            end
            IDX_SECURITY_KEY: begin
               regRdData <= {15'h0000, keyUnlocked};
            end
            default: begin
               regRdData <= 16'h0000;
            end
         endcase
      end else begin
         regRdData <= 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin outputs, registered
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sysResetOutN <= 1'b0;
         memory_reset_out_n <= 1'b0;
         irqOut <= 1'b0;
         comparatorEnable <= 1'b1;
         thermalEnable <= 1'b1;
         startupActive <= 1'b0;
         hibernateActive <= 1'b0;
      end else begin
         case (powerState)
            ST_HIBERNATE: begin
               sysResetOutN <= hibCtrl[HIB_RSTPIN_BIT];
               memory_reset_out_n <= hibCtrl[HIB_MEMORY_RESET_OUT_N_BIT];
            end
            ST_ACTIVE: begin
               sysResetOutN <= 1'b1;
               memory_reset_out_n <= 1'b1;
            end
            default: begin
               sysResetOutN <= 1'b0;
               memory_reset_out_n <= 1'b0;
            end
         endcase
         irqOut <= |(irqStatus & ~irqMask) && !(inHib && hibCtrl[HIB_IRQMASK_BIT]);
         comparatorEnable <= !inHib || hibCtrl[HIB_COMP_BIT];
         thermalEnable <= !inHib || hibCtrl[HIB_THERM_BIT];
         startupActive <= powerState == ST_STARTUP;
         hibernateActive <= inHib;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   chk_off_no_expiry: assert property (@(posedge clk) disable iff (sys_rst)
      watchdog_action_select == ACTION_OFF |-> !expiry && !wdResetReq)
      else $error("watchdog expired while disabled");

   chk_irq_mode_noreset: assert property (@(posedge clk) disable iff (sys_rst)
      expiry && watchdog_action_select == ACTION_IRQ |=> irqStatus[IRQ_TIMEOUT_BIT] && powerState != ST_SYSRESET)
      else $error("interrupt-only mode misbehaved");

   chk_reset_mode: assert property (@(posedge clk) disable iff (sys_rst)
      expiry && watchdog_action_select == ACTION_RESET_ONLY
      |=> powerState == ST_SYSRESET && irqStatus[IRQ_RESET_WAKE_BIT] ##1 !sysResetOutN)
      else $error("reset mode did not reset");

   chk_two_stage_first: assert property (@(posedge clk) disable iff (sys_rst)
      expiry && watchdog_action_select == ACTION_TWO_STAGE && !firstExpired
      |=> firstExpired && powerState != ST_SYSRESET)
      else $error("first expiry reset the system");

   chk_key_protect: assert property (@(posedge clk) disable iff (sys_rst)
      wrCtrl2 && !keyUnlocked && !regClear |=> $stable(watchdog_action_select))
      else $error("locked action field changed");

   chk_beat_reload: assert property (@(posedge clk) disable iff (sys_rst)
      beatEdge |=> wdCount == $past(reloadValue) && !firstExpired)
      else $error("host_alive_pulse did not reload timer");

   chk_period_reserved: assert property (@(posedge clk) disable iff (sys_rst)
      watchdog_period_select[2:1] != 2'h3)
      else $error("reserved period code stored");

   chk_hib_clear: assert property (@(posedge clk) disable iff (sys_rst)
      wdResetReq |=> !hibCtrl[HIB_STATE_BIT])
      else $error("hibernate bit survived reset");

   chk_hib_wdog_off: assert property (@(posedge clk) disable iff (sys_rst)
      inHib && !hibCtrl[HIB_WDOG_BIT] |-> !wdRunning)
      else $error("watchdog ran in hibernate");

   chk_exit_startup: assert property (@(posedge clk) disable iff (sys_rst)
      hibExit && hibCtrl[HIB_STARTUP_BIT] && !wdResetReq |=> powerState == ST_STARTUP ##1 startupActive)
      else $error("startup sequence skipped");

   chk_hib_pins: assert property (@(posedge clk) disable iff (sys_rst)
      inHib |=> sysResetOutN == $past(hibCtrl[HIB_RSTPIN_BIT])
      && memory_reset_out_n == $past(hibCtrl[HIB_MEMORY_RESET_OUT_N_BIT]))
      else $error("hibernate pin level wrong");

   chk_irq_forced: assert property (@(posedge clk) disable iff (sys_rst)
      inHib && hibCtrl[HIB_IRQMASK_BIT] |=> !irqOut)
      else $error("interrupt shown in hibernate");

   chk_write_reload: assert property (@(posedge clk) disable iff (sys_rst)
      wrCtrl2 && keyUnlocked && !regClear |=> wdCount == (6'h1 << watchdog_period_select))
      else $error("write did not reload with new period");

   chk_exit_clear: assert property (@(posedge clk) disable iff (sys_rst)
      hibExit && hibCtrl[HIB_REGCLR_BIT] |=> watchdog_action_select == ACTION_RESET
      && watchdog_period_select == PERIOD_RESET && hibCtrl == HIB_RESET)
      else $error("registers kept on clearing exit");

   chk_sleep_comparator: assert property (@(posedge clk) disable iff (sys_rst)
      inHib |=> comparatorEnable == $past(hibCtrl[HIB_COMP_BIT]))
      else $error("comparator enable wrong in hibernate");

   chk_sleep_thermal: assert property (@(posedge clk) disable iff (sys_rst)
      inHib |=> thermalEnable == $past(hibCtrl[HIB_THERM_BIT]))
      else $error("thermal enable wrong in hibernate");

endmodule

// >>> host_alive_model.sv
`timescale 1ns/1ns
module host_alive_model #(
   parameter int KICK_CYCLES = 3
) (
   input wire logic clk,
   input wire logic kickEn,
   output logic host_alive_pulse
);
   int count = 0;

   initial host_alive_pulse = 1'b0;

   // Service by toggling; either edge reloads the timer
   always @(posedge clk) begin
      if (kickEn) begin
         count <= (count == KICK_CYCLES - 1) ? 0 : count + 1;
         if (count == KICK_CYCLES - 1) begin
            host_alive_pulse <= ~host_alive_pulse;
         end
      end
   end
endmodule

// >>> tb_top.sv
`timescale 1ns/1ns
module tb_top;
   import watchdog_hibernate_pkg::*;
   localparam int TP = 4;
   logic clk, sys_rst, regWr, regRd, kickEn;
   logic [7:0] regAddr;
   logic [15:0] regWrData, regRdData, rd;
   logic host_alive_pulse, sysResetOutN, memory_reset_out_n, irqOut;
   logic comparatorEnable, thermalEnable, startupActive, hibernateActive;
   int mismatches = 0;
   int n_checks = 0;
   int cycles = 0;
   int n;

   watchdog_hibernate_control #(.TICK_PERIOD(TP)) uut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .host_alive_pulse(host_alive_pulse), .sysResetOutN(sysResetOutN),
      .memory_reset_out_n(memory_reset_out_n), .irqOut(irqOut), .comparatorEnable(comparatorEnable),
      .thermalEnable(thermalEnable), .startupActive(startupActive), .hibernateActive(hibernateActive));

   host_alive_model #(.KICK_CYCLES(3)) host (.clk(clk), .kickEn(kickEn), .host_alive_pulse(host_alive_pulse));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      if (mismatches == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         final_report();
      end
   end

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask

   task automatic rdReg(input logic [7:0] a);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 rd = regRdData;
   endtask

   task automatic rdCheck(input string what, input logic [7:0] a, input logic [15:0] exp);
      rdReg(a);
      check(what, exp, rd);
   endtask

   // Sel 0 watches the interrupt, 1 the system reset pin
   task automatic waitPin(input int sel, input logic v, output int k);
      k = 0;
      while (((sel == 0) ? irqOut : sysResetOutN) !== v && k < 300) begin
         @(posedge clk);
         #1;
         k++;
      end
   endtask

   function automatic logic [15:0] pins();
      return {11'h000, sysResetOutN, memory_reset_out_n, irqOut, comparatorEnable, thermalEnable};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   task automatic testResetValues();
      rdCheck("control", 8'h10, 16'h0004);
      rdCheck("hibernate", 8'h14, 16'h0000);
      rdCheck("unmapped", 8'h30, 16'h0000);
      check("pins", 16'h001B, pins());
      wr(8'h10, 16'h0010);
      rdCheck("locked control", 8'h10, 16'h0004);
      wr(8'h28, KEY_UNLOCK);
      wr(8'h10, 16'h0016);
      rdCheck("reserved period", 8'h10, 16'h0014);
      wr(8'h10, 16'h0000);
   endtask

   task automatic testTimeout();
      for (int p = 0; p < 4; p++) begin
         wr(8'h10, 16'h0000);
         rdReg(8'h20);
         cyc(2);
         check("irq idle", 16'h0000, {15'h0, irqOut});
         wr(8'h10, 16'h0010 | 16'(p));
         waitPin(0, 1'b1, n);
         check("expiry window", 16'h0001, 16'(n >= ((1 << p) - 1) * TP && n <= (1 << p) * TP + 6));
      end
      rdCheck("status", 8'h20, 16'h0001);
      check("reset pin", 16'h0001, {15'h0, sysResetOutN});
      wr(8'h10, 16'h0000);
      rdReg(8'h20);
      cyc(40);
      rdCheck("disabled status", 8'h20, 16'h0000);
      wr(8'h24, 16'h0001);
      wr(8'h10, 16'h0010);
      cyc(20);
      check("masked irq", 16'h0000, {15'h0, irqOut});
      rdCheck("masked status", 8'h20, 16'h0001);
      wr(8'h24, 16'h0000);
   endtask

   task automatic testHeartbeat();
      @(posedge clk);
      kickEn <= 1'b1;
      wr(8'h10, 16'h0011);
      rdReg(8'h20);
      cyc(100);
      rdCheck("status kicked", 8'h20, 16'h0000);
      @(posedge clk);
      kickEn <= 1'b0;
      cyc(40);
      rdCheck("status unkicked", 8'h20, 16'h0001);
      wr(8'h10, 16'h0011);
      rdReg(8'h20);
      repeat (25) begin
         wr(8'h10, 16'h0011);
         cyc(1);
      end
      rdCheck("status rewritten", 8'h20, 16'h0000);
      wr(8'h10, 16'h0000);
      rdReg(8'h20);
   endtask

   task automatic testResetAction();
      wr(8'h10, 16'h0020);
      waitPin(1, 1'b0, n);
      check("reset asserted", 16'h0001, 16'(n < 20));
      waitPin(1, 1'b1, n);
      check("reset length", 16'(SYS_RESET_CYCLES), 16'(n));
      rdCheck("reset status", 8'h20, 16'h0002);
      rdCheck("control default", 8'h10, 16'h0004);
   endtask

   task automatic testTwoStage();
      wr(8'h28, KEY_UNLOCK);
      wr(8'h10, 16'h0030);
      waitPin(0, 1'b1, n);
      check("first expiry reset pin", 16'h0001, {15'h0, sysResetOutN});
      waitPin(1, 1'b0, n);
      check("second expiry", 16'h0001, 16'(n < 20));
      waitPin(1, 1'b1, n);
      rdCheck("two-stage status", 8'h20, 16'h0003);
   endtask

   task automatic testHibernate();
      wr(8'h28, KEY_UNLOCK);
      wr(8'h10, 16'h0010);
      waitPin(0, 1'b1, n);
      wr(8'h14, 16'h8008);
      cyc(2);
      check("sleep flag", 16'h0001, {15'h0, hibernateActive});
      check("pins", 16'h0000, pins());
      rdReg(8'h20);
      cyc(40);
      rdCheck("sleep status", 8'h20, 16'h0000);
      wr(8'h14, 16'h8097);
      cyc(40);
      check("pins", 16'h001F, pins());
      rdCheck("sleep status", 8'h20, 16'h0001);
      wr(8'h14, 16'h0040);
      cyc(2);
      check("startup", 16'h0001, {15'h0, startupActive});
      cyc(20);
      check("startup done", 16'h0000, {14'h0, startupActive, hibernateActive});
      rdCheck("kept control", 8'h10, 16'h0010);
      wr(8'h14, 16'h8020);
      wr(8'h14, 16'h0020);
      cyc(2);
      check("direct exit", 16'h0000, {14'h0, startupActive, hibernateActive});
      rdCheck("cleared hibernate", 8'h14, 16'h0000);
      rdCheck("cleared control", 8'h10, 16'h0004);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_rst = 1'b1;
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 8'h00;
      regWrData = 16'h0000;
      kickEn = 1'b0;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      cyc(1);
      testResetValues();
      testTimeout();
      testHeartbeat();
      testResetAction();
      testTwoStage();
      testHibernate();
      final_report();
   end
endmodule
